// ===== rtl/tws_link.sv
`timescale 1ns/100ps
// ============================================================
// link side sampler, clocked by the bus clock line
module tws_link (
   // link clock and reset
   input  wire logic i_link_clk,
   input  wire logic i_nrst,
   // data line
   input  wire logic i_sda,
   // sample and its event toggle
   output logic      o_bit,
   output logic      o_tgl
);
   // sample data on each rising bus clock; toggle marks it
   always_ff @(posedge i_link_clk or negedge i_nrst) begin
      if (!i_nrst) begin
         o_bit <= 1'b1;
         o_tgl <= 1'b0;
      end else begin
         o_bit <= i_sda;
         o_tgl <= ~o_tgl;
      end
   end
endmodule // tws_link

// ===== rtl/tws_pkg.sv
// ============================================================
// shared constants and types
package tws_pkg;
   // register offsets
   localparam logic [7:0] OFS_SADR  = 8'hd9;
   localparam logic [7:0] OFS_DAT   = 8'hda;
   localparam logic [7:0] OFS_FLAGS = 8'he1;
   localparam logic [7:0] OFS_CFG   = 8'he2;
   // main config field positions
   localparam int CFG_ON    = 0;
   localparam int CFG_ROLE  = 1;
   localparam int CFG_RATE  = 2;
   localparam int CFG_START = 4;
   localparam int CFG_STOP  = 5;
   localparam int CFG_GC    = 7;
   // flag register field positions
   localparam int FLG_DONE  = 0;
   localparam int FLG_ACKN  = 1;
   localparam int FLG_HIT   = 2;
   localparam int FLG_STOP  = 3;
   localparam int FLG_GC    = 4;
   localparam int FLG_MASK  = 5;
   // values after reset
   localparam logic [7:0] RST_CFG   = 8'h80;
   localparam logic [6:0] RST_SADR  = 7'h00;
   localparam logic [7:0] RST_DAT   = 8'h00;
   localparam logic [4:0] RST_FLAGS = 5'h00;
   // rate field codes
   localparam logic [1:0] RATE_IDLE = 2'h0;
   localparam logic [1:0] RATE_STD  = 2'h1;
   localparam logic [1:0] RATE_FAST = 2'h2;
   localparam logic [6:0] GC_ADDR   = 7'h00;
   // bit slot numbers in one byte frame
   localparam logic [3:0] SLOT_LAST = 4'h7;
   localparam logic [3:0] SLOT_ACK  = 4'h8;
   localparam logic [4:0] PH_LAST   = 5'h11;
   // timing, in ns, and derived cycle counts
   localparam int CLK_PERIOD_NS  = 5;
   localparam int STD_PERIOD_NS  = 10000;
   localparam int FAST_PERIOD_NS = 2500;
   localparam logic [10:0] STD_HALF_CYC  = 11'(STD_PERIOD_NS / (2 * CLK_PERIOD_NS));
   localparam logic [10:0] FAST_HALF_CYC = 11'(FAST_PERIOD_NS / (2 * CLK_PERIOD_NS));
   // master sequencer states
   typedef enum logic [4:0] {
      M_IDLE   = 5'b00001,
      M_START  = 5'b00010,
      M_BIT    = 5'b00100,
      M_RSTART = 5'b01000,
      M_STOP   = 5'b10000
   } tws_mst_t;
   // half period of the bus clock for a rate code
   function automatic logic [10:0] half_count(input logic [1:0] rate);
      half_count = (rate == RATE_FAST) ? FAST_HALF_CYC : STD_HALF_CYC;
   endfunction
   // rate code that lets the master run
   function automatic logic rate_ok(input logic [1:0] rate);
      rate_ok = (rate == RATE_STD) || (rate == RATE_FAST);
   endfunction
endpackage

// ===== rtl/tws_sync.sv
`timescale 1ns/100ps
// ============================================================
// two flop level synchroniser
module tws_sync #(
   parameter int W = 3
) (
   // clock and reset
   input  wire logic         i_clk_sys,
   input  wire logic         i_nrst,
   // levels
   input  wire logic [W-1:0] i_async,
   output logic      [W-1:0] o_sync
);
   logic [W-1:0] meta_r;  // first stage, read only by second
   // two stages
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         meta_r <= '0;
         o_sync <= '0;
      end else begin
         meta_r <= i_async;
         o_sync <= meta_r;
      end
   end
endmodule // tws_sync

// ===== rtl/tws_top.sv
`timescale 1ns/100ps
// ============================================================
// What this block does
// [RULE_01] enable bit runs core, clear stops it
// [RULE_02] software enables first, separate write
// [RULE_03] mask bit five blocks every interrupt
// [RULE_04] software sets mask before any transfer
// [RULE_05] general call flag marks address zero
// [RULE_06] slave sets stop flag on stop
// [RULE_07] slave sets hit flag on own address
// [RULE_08] ack bit holds last transmit acknowledge
// [RULE_09] byte done flag set per byte
// [RULE_10] reading flag register clears flags four:zero
// [RULE_11] slave answers only its seven bit address
// [RULE_12] data writes transmit buffer, reads receive buffer
// [RULE_13] role bit and rate field select operation
// [RULE_14] system clock fast enough for chosen rate
// [RULE_15] rate codes idle, standard, fast, reserved
// [RULE_16] general call accept adds address zero
// [RULE_17] stop request sends stop, self clears
// [RULE_18] start request sends start, self clears
// [RULE_19] pulse interrupt on unmasked flag set; code skips slave hit with start_req set, slave stop with stop_req set
module tws_top (
   // system clock and reset
   input  wire logic       i_clk_sys,
   input  wire logic       i_nrst,
   // register port
   input  wire logic [7:0] i_sfr_addr,
   input  wire logic [7:0] i_sfr_wdata,
   input  wire logic       i_sfr_wr,
   input  wire logic       i_sfr_rd,
   output logic      [7:0] o_sfr_rdata,
   output logic            o_irq,
   // bus clock line, also the link clock
   input  wire logic       i_scl_clk,
   output logic            o_scl_out,
   output logic            o_scl_oe_n,
   // bus data line
   input  wire logic       i_sda,
   output logic            o_sda_out,
   output logic            o_sda_oe_n
);
   // ============================================================
   // reset release and pin crossing
   logic rst_meta_r, rst_n;       // reset release stages
   logic [2:0] pin_s;             // synced {tgl, sda, scl}
   logic scl_d_r, sda_d_r, tgl_d_r;  // previous synced levels
   logic link_bit, link_tgl;      // link domain sample

   // release reset through two flops
   always_ff @(posedge i_clk_sys or negedge i_nrst) begin
      if (!i_nrst) begin
         rst_meta_r <= 1'b0;
         rst_n      <= 1'b0;
      end else begin
         rst_meta_r <= 1'b1;
         rst_n      <= rst_meta_r;
      end
   end

   tws_link u_link (
      .i_link_clk (i_scl_clk),
      .i_nrst     (rst_n),
      .i_sda      (i_sda),
      .o_bit      (link_bit),
      .o_tgl      (link_tgl)
   );

   tws_sync #(.W(3)) u_sync (
      .i_clk_sys (i_clk_sys),
      .i_nrst    (rst_n),
      .i_async   ({link_tgl, i_sda, i_scl_clk}),
      .o_sync    (pin_s)
   );

   // previous levels for edge finding
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
         tgl_d_r <= 1'b0;
      end else begin
         scl_d_r <= pin_s[0];
         sda_d_r <= pin_s[1];
         tgl_d_r <= pin_s[2];
      end
   end

   // ============================================================
   // register state
   logic [7:0] cfg_r;             // main config
   logic [6:0] sadr_r;            // own slave address
   logic [7:0] tx_buf_r, rx_buf_r;
   logic       tx_full_r;         // transmit byte pending
   logic [4:0] flag_r;            // status flags
   logic       mask_irq_r;        // global interrupt mask
   logic       core_on, master, gc_accept, start_req, stop_req;
   logic [1:0] rate;
   assign core_on   = cfg_r[tws_pkg::CFG_ON];
   assign master    = cfg_r[tws_pkg::CFG_ROLE];    // [RULE_13]
   assign rate      = cfg_r[tws_pkg::CFG_RATE +: 2];
   assign start_req = cfg_r[tws_pkg::CFG_START];
   assign stop_req  = cfg_r[tws_pkg::CFG_STOP];
   assign gc_accept = cfg_r[tws_pkg::CFG_GC];

   // ============================================================
   // bus events
   logic link_edge, bus_start, bus_stop, scl_fall;
   assign link_edge = pin_s[2] ^ tgl_d_r;
   assign bus_start = pin_s[0] & scl_d_r & sda_d_r & ~pin_s[1];
   assign bus_stop  = pin_s[0] & scl_d_r & ~sda_d_r & pin_s[1];
   assign scl_fall  = scl_d_r & ~pin_s[0];

   // ============================================================
   // byte framing
   logic [3:0] cnt_r;             // bit slot in frame
   logic [7:0] sh_r;              // received bits
   logic       first_r;           // address byte in progress
   logic       in_frame_r;        // between start and stop
   logic       addressed_r;       // slave selected
   logic       rd_dir_r;          // read direction of frame
   logic [7:0] rx_byte;
   logic       byte_evt, ack_evt, addr_evt;
   logic       hit_own, hit_gc, tx_role, rx_role;
   assign rx_byte  = {sh_r[6:0], link_bit};
   assign byte_evt = link_edge & in_frame_r & (cnt_r == tws_pkg::SLOT_LAST);
   assign ack_evt  = link_edge & in_frame_r & (cnt_r == tws_pkg::SLOT_ACK);
   assign addr_evt = byte_evt & first_r & ~master;
   assign hit_own  = rx_byte[7:1] == sadr_r;                        // [RULE_11]
   assign hit_gc   = (rx_byte[7:1] == tws_pkg::GC_ADDR) & gc_accept; // [RULE_16]
   assign tx_role  = master ? (first_r | ~rd_dir_r) : (addressed_r & rd_dir_r & ~first_r);
   assign rx_role  = ~first_r & (master ? rd_dir_r : (addressed_r & ~rd_dir_r));

   // frame tracking from link samples
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cnt_r       <= 4'h0;
         sh_r        <= 8'h00;
         first_r     <= 1'b0;
         in_frame_r  <= 1'b0;
         addressed_r <= 1'b0;
         rd_dir_r    <= 1'b0;
      end else if (!core_on || bus_stop) begin
         // idle core or end of frame
         cnt_r       <= 4'h0;
         in_frame_r  <= 1'b0;
         addressed_r <= 1'b0;
      end else if (bus_start) begin
         // start or repeated start
         cnt_r       <= 4'h0;
         first_r     <= 1'b1;
         in_frame_r  <= 1'b1;
         addressed_r <= 1'b0;
      end else if (link_edge && in_frame_r) begin
         if (cnt_r == tws_pkg::SLOT_ACK) begin
            cnt_r   <= 4'h0;
            first_r <= 1'b0;
         end else begin
            sh_r  <= rx_byte;
            cnt_r <= cnt_r + 4'h1;
         end
         if (byte_evt && first_r) begin
            rd_dir_r <= rx_byte[0];
            if (!master) begin
               addressed_r <= hit_own | hit_gc;  // [RULE_11] [RULE_16]
            end
         end
      end
   end

   // ============================================================
   // master sequencer
   tws_pkg::tws_mst_t mst_state_r;
   logic [10:0] hp_cnt_r;         // half period countdown
   logic [4:0]  ph_r;             // clock phase in byte
   logic        mst_scl_low_r, mst_sda_low_r;
   logic        tick, stretched, go_start, go_rstart, stop_done;
   assign tick      = hp_cnt_r == 11'h000;
   assign stretched = ~mst_scl_low_r & ~pin_s[0];
   // start only on a tick, so the request bit is never dropped unsent
   assign go_start  = (mst_state_r == tws_pkg::M_IDLE) & tick & core_on & master & start_req
                    & tws_pkg::rate_ok(rate);                       // [RULE_15]
   assign go_rstart = (mst_state_r == tws_pkg::M_BIT) & tick & (ph_r == 5'h00) & ~stop_req & start_req
                    & ~(tx_full_r & tx_role);                       // [RULE_18]
   assign stop_done = (mst_state_r == tws_pkg::M_STOP) & tick & ~mst_scl_low_r;

   // start, byte clocking, repeated start and stop
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         mst_state_r   <= tws_pkg::M_IDLE;
         hp_cnt_r      <= 11'h000;
         ph_r          <= 5'h00;
         mst_scl_low_r <= 1'b0;
         mst_sda_low_r <= 1'b0;
      end else if (!core_on || !master) begin
         // core stopped or slave: release the lines
         mst_state_r   <= tws_pkg::M_IDLE;   // [RULE_01]
         mst_scl_low_r <= 1'b0;
         mst_sda_low_r <= 1'b0;
      end else if (!tick) begin
         // count down unless a slave holds the clock
         if (!stretched) begin
            hp_cnt_r <= hp_cnt_r - 11'h001;
         end
      end else begin
         hp_cnt_r <= tws_pkg::half_count(rate);
         case (mst_state_r)
            tws_pkg::M_IDLE: begin
               if (go_start) begin
                  mst_sda_low_r <= 1'b1;                          // [RULE_18]
                  mst_state_r   <= tws_pkg::M_START;
               end
            end
            tws_pkg::M_START: begin
               mst_scl_low_r <= 1'b1;
               ph_r          <= 5'h00;
               mst_state_r   <= tws_pkg::M_BIT;
            end
            tws_pkg::M_BIT: begin
               if (ph_r != 5'h00) begin
                  mst_scl_low_r <= ~mst_scl_low_r;
                  ph_r          <= (ph_r == tws_pkg::PH_LAST) ? 5'h00 : ph_r + 5'h01;
               end else if ((tx_full_r && tx_role) || (rd_dir_r && !first_r && !stop_req && !start_req)) begin
                  // pending transmit byte goes out before any stop or start
                  mst_scl_low_r <= 1'b0;
                  ph_r          <= 5'h01;
               end else if (stop_req) begin
                  mst_sda_low_r <= 1'b1;                          // [RULE_17]
                  mst_state_r   <= tws_pkg::M_STOP;
               end else if (start_req) begin
                  mst_sda_low_r <= 1'b0;                          // [RULE_18]
                  mst_state_r   <= tws_pkg::M_RSTART;
               end
            end
            tws_pkg::M_RSTART: begin
               if (mst_scl_low_r) begin
                  mst_scl_low_r <= 1'b0;
               end else begin
                  mst_sda_low_r <= 1'b1;
                  mst_state_r   <= tws_pkg::M_START;
               end
            end
            tws_pkg::M_STOP: begin
               if (mst_scl_low_r) begin
                  mst_scl_low_r <= 1'b0;
               end else begin
                  mst_sda_low_r <= 1'b0;                          // [RULE_17]
                  mst_state_r   <= tws_pkg::M_IDLE;
               end
            end
            default: begin
               mst_state_r <= tws_pkg::M_IDLE;
            end
         endcase
      end
   end

   // ============================================================
   // data line drive per bit slot
   logic slot_low_r;              // drive data low this slot
   logic ack_drive;
   assign ack_drive = master ? (rd_dir_r & ~first_r & ~stop_req) : (addressed_r & (first_r | ~rd_dir_r));

   // choose the data level on each falling bus clock
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         slot_low_r <= 1'b0;
      end else if (!core_on || !in_frame_r || bus_start) begin
         slot_low_r <= 1'b0;
      end else if (scl_fall) begin
         if (cnt_r == tws_pkg::SLOT_ACK) begin
            slot_low_r <= ack_drive;
         end else begin
            slot_low_r <= tx_role & ~tx_buf_r[3'(tws_pkg::SLOT_LAST - cnt_r)];
         end
      end
   end

   // open drain pins, registered
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_scl_oe_n <= 1'b1;
         o_sda_oe_n <= 1'b1;
      end else begin
         o_scl_oe_n <= ~(master & mst_scl_low_r);
         if (master && mst_state_r != tws_pkg::M_BIT) begin
            o_sda_oe_n <= ~mst_sda_low_r;
         end else begin
            o_sda_oe_n <= ~slot_low_r;
         end
      end
   end
   assign o_scl_out = 1'b0;
   assign o_sda_out = 1'b0;

   // ============================================================
   // register writes and hardware updates
   logic wr_cfg, wr_flags, rd_flags;
   assign wr_cfg   = i_sfr_wr & (i_sfr_addr == tws_pkg::OFS_CFG);
   assign wr_flags = i_sfr_wr & (i_sfr_addr == tws_pkg::OFS_FLAGS);
   assign rd_flags = i_sfr_rd & (i_sfr_addr == tws_pkg::OFS_FLAGS);

   // main config; start and stop requests only set by writes
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         cfg_r <= tws_pkg::RST_CFG;
      end else begin
         if (wr_cfg && core_on) begin
            cfg_r <= i_sfr_wdata;
            cfg_r[tws_pkg::CFG_START] <= start_req & ~(go_start | go_rstart)
                                       | i_sfr_wdata[tws_pkg::CFG_START];
            cfg_r[tws_pkg::CFG_STOP]  <= stop_req & ~stop_done | i_sfr_wdata[tws_pkg::CFG_STOP];
         end else begin
            if (wr_cfg) begin
               cfg_r[tws_pkg::CFG_ON] <= i_sfr_wdata[tws_pkg::CFG_ON];  // [RULE_02]
            end
            if (go_start || go_rstart) begin
               cfg_r[tws_pkg::CFG_START] <= 1'b0;                      // [RULE_18]
            end
            if (stop_done) begin
               cfg_r[tws_pkg::CFG_STOP] <= 1'b0;                       // [RULE_17]
            end
         end
      end
   end

   // address, buffers and pending flag
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         sadr_r    <= tws_pkg::RST_SADR;
         tx_buf_r  <= tws_pkg::RST_DAT;
         rx_buf_r  <= tws_pkg::RST_DAT;
         tx_full_r <= 1'b0;
      end else begin
         if (i_sfr_wr && i_sfr_addr == tws_pkg::OFS_SADR) begin
            sadr_r <= i_sfr_wdata[6:0];
         end
         if (byte_evt && rx_role) begin
            rx_buf_r <= rx_byte;                                     // [RULE_12]
         end
         if (i_sfr_wr && i_sfr_addr == tws_pkg::OFS_DAT) begin
            tx_buf_r  <= i_sfr_wdata;                                // [RULE_12]
            tx_full_r <= 1'b1;
         end else if (byte_evt && tx_role) begin
            tx_full_r <= 1'b0;
         end
      end
   end

   // ============================================================
   // status flags; a set in the read cycle wins over the clear
   logic set_done, set_hit, set_stop, ack_upd;
   assign set_done = ack_evt & (master | addressed_r);                 // [RULE_09]
   assign set_hit  = addr_evt & (hit_own | hit_gc);                    // [RULE_07]
   assign set_stop = bus_stop & ~master & addressed_r;                 // [RULE_06]
   assign ack_upd  = ack_evt & tx_role;

   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         flag_r     <= tws_pkg::RST_FLAGS;
         mask_irq_r <= 1'b0;
      end else begin
         if (wr_flags) begin
            mask_irq_r <= i_sfr_wdata[tws_pkg::FLG_MASK];
         end
         flag_r[tws_pkg::FLG_DONE] <= flag_r[tws_pkg::FLG_DONE] & ~rd_flags | set_done;  // [RULE_10]
         flag_r[tws_pkg::FLG_HIT]  <= flag_r[tws_pkg::FLG_HIT] & ~rd_flags | set_hit;
         flag_r[tws_pkg::FLG_STOP] <= flag_r[tws_pkg::FLG_STOP] & ~rd_flags | set_stop;
         if (ack_upd) begin
            flag_r[tws_pkg::FLG_ACKN] <= link_bit;                      // [RULE_08]
         end else if (rd_flags) begin
            flag_r[tws_pkg::FLG_ACKN] <= 1'b0;
         end
         if (addr_evt) begin
            flag_r[tws_pkg::FLG_GC] <= hit_gc;                          // [RULE_05]
         end else if (rd_flags) begin
            flag_r[tws_pkg::FLG_GC] <= 1'b0;
         end
      end
   end

   // one cycle interrupt pulse on unmasked flag set, bar slave hit with start_req or slave stop with stop_req
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_irq <= 1'b0;
      end else begin
         o_irq <= ~mask_irq_r & (set_done                                 // [RULE_03] [RULE_19]
                  | set_hit & ~(~master & start_req)
                  | set_stop & ~(~master & stop_req));
      end
   end

   // registered read data, unmapped reads zero
   always_ff @(posedge i_clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         o_sfr_rdata <= 8'h00;
      end else if (i_sfr_rd) begin
         case (i_sfr_addr)
            tws_pkg::OFS_SADR:  o_sfr_rdata <= {1'b0, sadr_r};
            tws_pkg::OFS_DAT:   o_sfr_rdata <= rx_buf_r;
            tws_pkg::OFS_FLAGS: o_sfr_rdata <= {2'b00, mask_irq_r, flag_r};
            tws_pkg::OFS_CFG:   o_sfr_rdata <= cfg_r;
            default:            o_sfr_rdata <= 8'h00;
         endcase
      end
   end

   // ============================================================
   // checks
   default clocking cb @(posedge i_clk_sys); endclocking
   default disable iff (!rst_n);

   a_read_clears: assert property (rd_flags && !set_done && !set_hit && !set_stop && !ack_upd && !addr_evt
      |=> flag_r == 5'h00) else $error("flags not cleared by read"); // [RULE_10]
   a_mask_quiet: assert property (mask_irq_r && $past(mask_irq_r) |-> !o_irq)
      else $error("irq while masked"); // [RULE_03]
   a_done_irq: assert property (set_done && !mask_irq_r |=> o_irq && flag_r[tws_pkg::FLG_DONE])
      else $error("byte done without irq"); // [RULE_19]
   a_off_idle: assert property (!core_on |=> mst_state_r == tws_pkg::M_IDLE ##1 o_scl_oe_n)
      else $error("master active while off"); // [RULE_01]
   a_gc_flag: assert property (addr_evt && rx_byte[7:1] == tws_pkg::GC_ADDR && gc_accept
      |=> flag_r[tws_pkg::FLG_GC] && addressed_r) else $error("general call missed"); // [RULE_05]
   a_addr_hit: assert property (addr_evt && hit_own |=> flag_r[tws_pkg::FLG_HIT] && addressed_r)
      else $error("own address missed"); // [RULE_07]
   a_ack_capture: assert property (ack_upd |=> flag_r[tws_pkg::FLG_ACKN] == $past(link_bit))
      else $error("ack bit wrong"); // [RULE_08]
   a_stop_clear: assert property ($fell(stop_req) |-> $past(stop_done))
      else $error("stop request cleared early"); // [RULE_17]
   a_start_clear: assert property ($fell(start_req) |-> $past(go_start | go_rstart))
      else $error("start request cleared early"); // [RULE_18]
   a_rate_idle: assert property (mst_state_r == tws_pkg::M_IDLE && !tws_pkg::rate_ok(rate)
      |=> mst_state_r == tws_pkg::M_IDLE) else $error("master left idle at idle rate"); // [RULE_15]
   a_tx_load: assert property (i_sfr_wr && i_sfr_addr == tws_pkg::OFS_DAT
      |=> tx_full_r && tx_buf_r == $past(i_sfr_wdata)) else $error("tx buffer not loaded"); // [RULE_12]

   c_addr_hit:  cover property (set_hit);
   c_slv_stop:  cover property (set_stop);
   c_mst_stop:  cover property (stop_done);
   c_mst_read:  cover property (byte_evt && rx_role && master);
endmodule // tws_top

// ===== tb/two_wire_status_and_buffers_tb.sv
`timescale 1ns/100ps
module two_wire_status_and_buffers_tb;
   // ============================================================
   // stimulus and wires
   logic       clk  = 1'b0;
   logic       nrst = 1'b0;
   logic       wr   = 1'b0;
   logic       rd   = 1'b0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wd   = 8'h00;
   logic [7:0] rdat;
   logic       irq, scl_oe_n, sda_oe_n, m_scl, m_sda;
   wire        scl  = m_scl & scl_oe_n;
   wire        sda  = m_sda & sda_oe_n;
   int         fail_count = 0;
   int         checks_done = 0;
   int         irqs = 0;
   tws_top dut_u (.i_clk_sys(clk), .i_nrst(nrst), .i_sfr_addr(addr), .i_sfr_wdata(wd), .i_sfr_wr(wr),
      .i_sfr_rd(rd), .o_sfr_rdata(rdat), .o_irq(irq), .i_scl_clk(scl), .o_scl_out(), .o_scl_oe_n(scl_oe_n),
      .i_sda(sda), .o_sda_out(), .o_sda_oe_n(sda_oe_n));
   tws_peer_model peer_u (.o_scl(m_scl), .o_sda(m_sda), .i_scl(scl), .i_sda(sda));
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (irq === 1'b1) irqs++;
   // ============================================================
   // tasks
   task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         fail_count++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk) #1;
      addr = a;
      wd = d;
      wr = 1'b1;
      @(posedge clk) #1;
      wr = 1'b0;
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      @(posedge clk) #1;
      addr = a;
      rd = 1'b1;
      @(posedge clk) #1;
      rd = 1'b0;
      cmp(rdat, exp);
   endtask
   // one frame from the peer, then flags, clear on read, irq
   task automatic t_frame(input logic [7:0] b, input logic ea, input logic [7:0] ef, input logic ei);
      logic ack;
      irqs = 0;
      peer_u.frame(b, ack);
      repeat (20) @(posedge clk);
      cmp({7'h00, ack}, {7'h00, ea});
      rd_chk(8'he1, ef);
      rd_chk(8'he1, ef & 8'h20);
      cmp({7'h00, irqs != 0}, {7'h00, ei});
   endtask
   // controller sends one byte to the peer with start and stop requested
   task automatic t_master(input logic [7:0] b, input logic nack, input logic [7:0] ef);
      logic [7:0] got;
      irqs = 0;
      wr_reg(8'hda, b);
      wr_reg(8'he2, 8'hbb);
      peer_u.listen(nack, got);
      repeat (1000) @(posedge clk);
      cmp(got, b);
      rd_chk(8'he2, 8'h8b);
      cmp({7'h00, scl_oe_n}, 8'h01);
      rd_chk(8'he1, ef);
      cmp({7'h00, irqs != 0}, 8'h01);
   endtask
   task automatic print_verdict;
      $display("checks=%0d mismatches=%0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   // ============================================================
   // main sequence and watchdog
   initial begin
      #300000;
      fail_count++;
      print_verdict;
   end
   initial begin
      repeat (10) @(posedge clk);
      #1 nrst = 1'b1;
      repeat (3) @(posedge clk);
      rd_chk(8'he2, 8'h80);
      rd_chk(8'he1, 8'h00);
      rd_chk(8'hd9, 8'h00);
      rd_chk(8'h00, 8'h00);
      wr_reg(8'he2, 8'h01);
      wr_reg(8'he2, 8'h81);
      rd_chk(8'he2, 8'h81);
      wr_reg(8'hd9, 8'hd5);
      rd_chk(8'hd9, 8'h55);
      wr_reg(8'hda, 8'h3c);
      rd_chk(8'hda, 8'h00);
      t_frame(8'haa, 1'b0, 8'h0d, 1'b1);
      t_frame(8'h00, 1'b0, 8'h1d, 1'b1);
      t_frame(8'h54, 1'b1, 8'h00, 1'b0);
      wr_reg(8'he1, 8'h20);
      t_frame(8'haa, 1'b0, 8'h2d, 1'b0);
      wr_reg(8'he1, 8'h00);
      t_master(8'ha4, 1'b0, 8'h01);
      t_master(8'h5a, 1'b1, 8'h03);
      wr_reg(8'he2, 8'h93);
      repeat (600) @(posedge clk);
      rd_chk(8'he2, 8'h93);
      cmp({7'h00, scl_oe_n}, 8'h01);
      print_verdict;
   end
endmodule // two_wire_status_and_buffers_tb

// ===== tb/tws_peer_model.sv
`timescale 1ns/100ps
// ============================================================
// peer bus device: controller frames, or addressed target
module tws_peer_model (
   output logic      o_scl,
   output logic      o_sda,
   input  wire logic i_scl,
   input  wire logic i_sda
);
   // both lines released, pulled up
   initial begin
      o_scl = 1'b1;
      o_sda = 1'b1;
   end
   // start, one byte msb first, ack slot, stop
   task automatic frame(input logic [7:0] b, output logic ack);
      o_sda = 1'b0;
      #40 o_scl = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         #20 o_sda = b[i];
         #20 o_scl = 1'b1;
         #40 o_scl = 1'b0;
      end
      #20 o_sda = 1'b1;
      #20 o_scl = 1'b1;
      #20 ack = i_sda;
      #20 o_scl = 1'b0;
      #20 o_sda = 1'b0;
      #20 o_scl = 1'b1;
      #40 o_sda = 1'b1;
   endtask
   // act as target: take one byte, answer in the ack slot
   task automatic listen(input logic nack, output logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         @(posedge i_scl) b[i] = i_sda;
      end
      @(negedge i_scl) #21 o_sda = nack;
      @(negedge i_scl) #21 o_sda = 1'b1;
   endtask
endmodule // tws_peer_model
